// File: design/usb_bulk_in_host.sv
// Host-side controller driving a peripheral bulk IN endpoint through its registers
`timescale 1ns/10ps
module usb_bulk_in_host
  import usb_bulk_host_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                                 MCLK,
  input  wire logic                                 SYS_RST,
  // User command port
  input  wire logic                                 CMD_VALID,
  output logic                                      CMD_READY,
  input  wire usb_bulk_host_pkg::cmd_s              CMD,
  output logic                                      DONE,
  output logic                                      STALL_SEEN,
  output logic [15:0]                               STATUS,
  // Packet words from the user
  input  wire logic                                 DIN_VALID,
  output logic                                      DIN_READY,
  input  wire logic [usb_bulk_host_pkg::DATA_W-1:0] DIN_DATA,
  // Device register access port
  output usb_bulk_host_pkg::dev_req_s               DEV_REQ,
  input  wire logic                                 DEV_ACK,
  input  wire logic [usb_bulk_host_pkg::DATA_W-1:0] DEV_RDATA,
  input  wire logic                                 DEV_INT
);

  import usb_bulk_host_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    state_e           st;
    state_e           ret;
    dev_req_s         req;
    logic [CNT_W-1:0] cnt;
    logic             stall_on;
    logic             dbl;
    logic             done;
    logic             stall_seen;
    logic [15:0]      status;
  } ctl_s;

  ctl_s              s_r;
  ctl_s              s_nxt;
  logic              buf_valid;
  logic              buf_pop;
  logic [DATA_W-1:0] buf_data;
  logic [15:0]       csr_keep;

  // ****************************************************************
  // Word buffer
  // ****************************************************************
  usb_pkt_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .in_valid  (DIN_VALID),
    .in_ready  (DIN_READY),
    .in_data   (DIN_DATA),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // Bulk pattern plus the stall request that must persist across writes
  assign csr_keep  = CSR_BULK_BASE | (16'(s_r.stall_on) << B_STALL_REQ);
  assign CMD_READY = (s_r.st == S_IDLE);
  assign buf_pop   = (s_r.st == S_LOAD) && (s_r.cnt != '0) && buf_valid;
  assign DEV_REQ   = s_r.req;
  assign DONE      = s_r.done;
  assign STALL_SEEN = s_r.stall_seen;
  assign STATUS    = s_r.status;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Each register access is issued here and completed in S_BUS
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.stall_seen = 1'b0;
    case (s_r.st)
      S_IDLE:
      begin
        if (CMD_VALID)
        begin
          s_nxt.st = S_BUS;
          s_nxt.req.wr = 1'b1;
          s_nxt.req.addr = ADDR_TXCSR;
          case (CMD.op)
            OP_CONFIG:
            begin
              // Payload limit uses the low 11 bits only
              s_nxt.req.addr = ADDR_MAXP;
              s_nxt.req.wdata = {21'h0, CMD.arg[PAYLOAD_W-1:0]};
              s_nxt.dbl = CMD.arg[15];
              s_nxt.ret = S_CFG_FSZ;
            end
            OP_SEND:
            begin
              // Words go first; zero words leads straight to packet ready
              s_nxt.req.wr = 1'b0;
              s_nxt.st = S_LOAD;
              s_nxt.cnt = CMD.arg[CNT_W-1:0];
            end
            OP_FLUSH:
            begin
              s_nxt.req.wdata = {16'h0, csr_keep | (16'h1 << B_DISCARD)};
              s_nxt.ret = s_r.dbl ? S_FLUSH2 : S_END;
            end
            OP_STALL_ON:
            begin
              s_nxt.stall_on = 1'b1;
              s_nxt.req.wdata = {16'h0, CSR_BULK_BASE |
                                 (16'h1 << B_STALL_REQ)};
              s_nxt.ret = S_END;
            end
            OP_STALL_OFF:
            begin
              // Re-enabling the pipe restarts the toggle sequence
              s_nxt.stall_on = 1'b0;
              s_nxt.req.wdata = {16'h0, CSR_BULK_BASE |
                                 (16'h1 << B_TOG_RESET)};
              s_nxt.ret = S_END;
            end
            default:
            begin
              s_nxt.req.wr = 1'b0;
              s_nxt.st = S_END;
            end
          endcase
        end
      end
      S_BUS:
      begin
        // Request held until the device acknowledges it
        if (DEV_ACK)
        begin
          s_nxt.req.wr = 1'b0;
          s_nxt.req.rd = 1'b0;
          s_nxt.st = s_r.ret;
          if (s_r.req.rd)
            s_nxt.status = DEV_RDATA[15:0];
        end
      end
      S_CFG_FSZ:
      begin
        s_nxt.st = S_BUS;
        s_nxt.req.wr = 1'b1;
        s_nxt.req.addr = ADDR_FIFOSZ;
        s_nxt.req.wdata = 32'(s_r.dbl) << B_DBL_BUF;
        s_nxt.ret = S_CFG_CSR;
      end
      S_CFG_CSR:
      begin
        // Every configuration: bulk pattern, toggle reset and discard
        s_nxt.st = S_BUS;
        s_nxt.req.wr = 1'b1;
        s_nxt.req.addr = ADDR_TXCSR;
        s_nxt.req.wdata = {16'h0, csr_keep | (16'h1 << B_TOG_RESET) |
                           (16'h1 << B_DISCARD)};
        s_nxt.ret = s_r.dbl ? S_FLUSH2 : S_END;
      end
      S_FLUSH2:
      begin
        // Two packets may sit in a double-buffered FIFO
        s_nxt.st = S_BUS;
        s_nxt.req.wr = 1'b1;
        s_nxt.req.addr = ADDR_TXCSR;
        s_nxt.req.wdata = {16'h0, csr_keep | (16'h1 << B_DISCARD)};
        s_nxt.ret = S_END;
      end
      S_LOAD:
      begin
        if (s_r.cnt == '0)
          s_nxt.st = S_ARM;
        else if (buf_valid)
        begin
          s_nxt.st = S_BUS;
          s_nxt.req.wr = 1'b1;
          s_nxt.req.addr = ADDR_FIFO;
          s_nxt.req.wdata = buf_data;
          s_nxt.cnt = s_r.cnt - 1'b1;
          s_nxt.ret = S_LOAD;
        end
      end
      S_ARM:
      begin
        s_nxt.st = S_BUS;
        s_nxt.req.wr = 1'b1;
        s_nxt.req.addr = ADDR_TXCSR;
        s_nxt.req.wdata = {16'h0, csr_keep | (16'h1 << B_PKT_READY)};
        s_nxt.ret = S_WAIT_INT;
      end
      S_WAIT_INT:
      begin
        // Interrupt means packet ready cleared or a stall went out
        if (DEV_INT)
        begin
          s_nxt.st = S_BUS;
          s_nxt.req.rd = 1'b1;
          s_nxt.req.addr = ADDR_TXCSR;
          s_nxt.ret = S_CHECK;
        end
      end
      S_CHECK:
      begin
        if (s_r.status[B_STALL_DONE])
        begin
          // Clear the flag but keep the stall request standing
          s_nxt.stall_seen = 1'b1;
          s_nxt.st = S_BUS;
          s_nxt.req.wr = 1'b1;
          s_nxt.req.addr = ADDR_TXCSR;
          s_nxt.req.wdata = {16'h0, csr_keep};
          s_nxt.ret = S_END;
        end
        else if (!s_r.status[B_PKT_READY])
          s_nxt.st = S_END;
        else
          s_nxt.st = S_WAIT_INT;
      end
      S_END:
      begin
        s_nxt.done = 1'b1;
        s_nxt.st = S_IDLE;
      end
      default:
        s_nxt.st = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      s_r <= '0;
      s_r.st <= S_IDLE;
      s_r.ret <= S_IDLE;
      s_r.status <= STATUS_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic csr_wr;
  assign csr_wr = DEV_REQ.wr && (DEV_REQ.addr == ADDR_TXCSR);

  a_csr_bulk_mode: assert property (@(posedge MCLK) disable iff (SYS_RST)
    csr_wr |-> !DEV_REQ.wdata[B_PERIODIC])
    else $error("periodic select set on control write");
  a_csr_dir_tx: assert property (@(posedge MCLK) disable iff (SYS_RST)
    csr_wr |-> DEV_REQ.wdata[B_DIR_TX])
    else $error("FIFO direction not transmit");
  a_csr_no_dma: assert property (@(posedge MCLK) disable iff (SYS_RST)
    csr_wr |-> !DEV_REQ.wdata[B_DMA_REQ] && !DEV_REQ.wdata[B_DMA_SUPP])
    else $error("DMA bits set by host controller");
  a_csr_no_force: assert property (@(posedge MCLK) disable iff (SYS_RST)
    csr_wr |-> !DEV_REQ.wdata[B_FORCED_TOG])
    else $error("forced toggle set");
  a_maxp_width: assert property (@(posedge MCLK) disable iff (SYS_RST)
    DEV_REQ.wr && DEV_REQ.addr == ADDR_MAXP |->
      DEV_REQ.wdata[31:PAYLOAD_W] == '0)
    else $error("payload limit wider than 11 bits");
  a_arm_after_load: assert property (@(posedge MCLK) disable iff (SYS_RST)
    csr_wr && DEV_REQ.wdata[B_PKT_READY] |-> s_r.cnt == '0)
    else $error("packet ready before all words loaded");
  a_stall_kept: assert property (@(posedge MCLK) disable iff (SYS_RST)
    csr_wr && s_r.stall_on |-> DEV_REQ.wdata[B_STALL_REQ])
    else $error("stall request dropped while stalled");
  // Take edge, then load and arm states, then the write is on the port
  a_zlp_arm: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CMD_READY && CMD_VALID && CMD.op == OP_SEND && CMD.arg[CNT_W-1:0] == '0
      |-> ##3 csr_wr && DEV_REQ.wdata[B_PKT_READY])
    else $error("zero-length send did not arm at once");
  a_unstall_toggle: assert property (@(posedge MCLK) disable iff (SYS_RST)
    CMD_READY && CMD_VALID && CMD.op == OP_STALL_OFF
      |=> csr_wr && DEV_REQ.wdata[B_TOG_RESET] && !DEV_REQ.wdata[B_STALL_REQ])
    else $error("re-enable without toggle reset");
  a_flush_twice: assert property (@(posedge MCLK) disable iff (SYS_RST)
    s_r.st == S_FLUSH2 |=> csr_wr && DEV_REQ.wdata[B_DISCARD])
    else $error("second discard missing");

endmodule // usb_bulk_in_host

// File: inc/usb_bulk_host_pkg.sv
// Constants, register map and types for the bulk IN endpoint host controller
package usb_bulk_host_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int CNT_W  = 11;

  // ****************************************************************
  // Device register indices on the device access port
  // ****************************************************************
  localparam logic [3:0] ADDR_TXCSR  = 4'h0; // tx_endpoint_control_status
  localparam logic [3:0] ADDR_MAXP   = 4'h1; // tx_max_payload_limit
  localparam logic [3:0] ADDR_FIFOSZ = 4'h2; // tx_fifo_size_config
  localparam logic [3:0] ADDR_FIFO   = 4'h3; // endpoint FIFO data port

  // ****************************************************************
  // Field positions of tx_endpoint_control_status
  // ****************************************************************
  localparam int B_PKT_READY  = 0;  // tx_packet_ready
  localparam int B_OCCUPIED   = 1;  // tx_fifo_occupied
  localparam int B_DISCARD    = 3;  // fifo_discard
  localparam int B_STALL_REQ  = 4;  // stall_request
  localparam int B_STALL_DONE = 5;  // stall_delivered
  localparam int B_TOG_RESET  = 6;  // toggle_reset
  localparam int B_DMA_SUPP   = 10; // dma_interrupt_suppress
  localparam int B_FORCED_TOG = 11; // forced_toggle
  localparam int B_DMA_REQ    = 12; // dma_request_enable
  localparam int B_DIR_TX     = 13; // FIFO direction select
  localparam int B_PERIODIC   = 14; // periodic-transfer select
  localparam int B_DBL_BUF    = 4;  // double_buffer_enable in fifo size cfg
  localparam int PAYLOAD_W    = 11; // Payload field width of max payload

  // Bulk base pattern: direction set, periodic/DMA/forced toggle clear
  localparam logic [15:0] CSR_BULK_BASE = 16'h2000;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;

  // ****************************************************************
  // Commands and states
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_CONFIG    = 3'h0,
    OP_SEND      = 3'h1,
    OP_FLUSH     = 3'h2,
    OP_STALL_ON  = 3'h3,
    OP_STALL_OFF = 3'h4
  } op_e;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_BUS      = 4'h1,
    S_CFG_FSZ  = 4'h2,
    S_CFG_CSR  = 4'h3,
    S_FLUSH2   = 4'h4,
    S_LOAD     = 4'h5,
    S_ARM      = 4'h6,
    S_WAIT_INT = 4'h7,
    S_CHECK    = 4'h8,
    S_END      = 4'h9
  } state_e;

  // Request toward the device access port
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dev_req_s;

  // User command
  typedef struct packed {
    op_e         op;
    logic [15:0] arg;
  } cmd_s;

endpackage

// File: design/usb_pkt_buffer.sv
// DEPTH-entry buffer (two by default) with valid/ready on both sides for outgoing words
`timescale 1ns/10ps
module usb_pkt_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } buf_s;

  buf_s r_r;
  buf_s r_nxt;
  logic push;
  logic pop;

  // Full and empty follow the stored count, so the source really stalls
  assign in_ready  = (r_r.cnt != (PW+1)'(DEPTH));
  assign out_valid = (r_r.cnt != '0);
  assign out_data  = r_r.mem[r_r.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update
  always_comb
  begin
    r_nxt = r_r;
    if (push)
    begin
      r_nxt.mem[r_r.wp] = in_data;
      r_nxt.wp = (r_r.wp == PW'(DEPTH-1)) ? '0 : r_r.wp + 1'b1;
    end
    if (pop)
      r_nxt.rp = (r_r.rp == PW'(DEPTH-1)) ? '0 : r_r.rp + 1'b1;
    r_nxt.cnt = r_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

endmodule // usb_pkt_buffer

// File: verification/usb_dev_model.sv
// Behavioural bulk IN endpoint device answering the host controller
`timescale 1ns/10ps
module usb_dev_model
  import usb_bulk_host_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register access port
  input  wire dev_req_s   req,
  output logic            ack,
  output logic [31:0]     rdata,
  output logic            intr,
  // Bench controls and view
  input  wire logic [1:0] ack_wait,
  input  wire logic       in_tok,
  output logic            sent,
  output logic [43:0]     sent_pkt,
  output logic [15:0]     csr,
  output logic [15:0]     maxp,
  output logic [15:0]     fsz
);
  logic [42:0] pkts[$];
  logic [42:0] cur;
  logic        tog;
  logic [1:0]  cnt;
  logic [15:0] w;

  // ****************************************************************
  // Registers, FIFO and token answers
  // ****************************************************************
  // One process, so a token never races a register write
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {ack, intr, sent, tog, cnt, rdata} <= '0;
      {csr, maxp, fsz, cur, sent_pkt} <= '0;
      pkts.delete();
    end
    else
    begin
      w = req.wdata[15:0];
      ack <= 1'b0;
      sent <= 1'b0;
      rdata <= ~rdata; // Idle read bus never holds stale data
      if ((req.wr || req.rd) && !ack && cnt != ack_wait)
        cnt <= cnt + 2'h1;
      else if ((req.wr || req.rd) && !ack)
      begin
        ack <= 1'b1;
        cnt <= '0;
        if (req.rd)
        begin
          rdata <= {16'h0, csr[15:2], pkts.size() != 0 || cur != 0, csr[0]};
          intr <= 1'b0;
        end
        else if (req.addr == ADDR_FIFO)
          cur <= {cur[42:32] + 11'h1, cur[31:0] + req.wdata};
        else if (req.addr == ADDR_MAXP)
          maxp <= w;
        else if (req.addr == ADDR_FIFOSZ)
          fsz <= w;
        else if (req.addr == ADDR_TXCSR)
        begin
          csr[15:10] <= w[15:10];
          csr[4] <= w[4];
          csr[5] <= csr[5] & w[5];
          if (w[6])
            tog <= 1'b0;
          if (w[3])
          begin
            csr[0] <= 1'b0;
            if (pkts.size() != 0)
              void'(pkts.pop_front());
            else
              cur <= '0;
          end
          else if (w[0])
          begin
            pkts.push_back(cur);
            cur <= '0;
            csr[0] <= !(fsz[4] && pkts.size() == 1);
            intr <= fsz[4] && pkts.size() == 1;
          end
        end
      end
      else if (in_tok && csr[4])
      begin
        csr[5] <= 1'b1;
        intr <= 1'b1;
      end
      else if (in_tok && pkts.size() != 0)
      begin
        sent <= 1'b1;
        sent_pkt <= {tog, pkts.pop_front()};
        tog <= ~tog;
        csr[0] <= 1'b0;
        // DMA with interrupt suppress keeps completions silent
        intr <= !(csr[12] && csr[10]);
      end
    end
  end
endmodule // usb_dev_model

// File: verification/usb_bulk_in_host_test.sv
// Self-checking bench for the bulk IN endpoint host controller
`timescale 1ns/10ps
module usb_bulk_in_host_test;
  import usb_bulk_host_pkg::*;
  logic        MCLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        CMD_VALID = 1'b0;
  cmd_s        CMD = '0;
  logic        DIN_VALID = 1'b0;
  logic [31:0] DIN_DATA = '0;
  logic        in_tok = 1'b0;
  logic        tok_en = 1'b0;
  logic        tog_x = 1'b0;
  logic [1:0]  ack_wait = 2'h0;
  logic [31:0] seed = 32'hAE51;
  logic        CMD_READY, DONE, STALL_SEEN, DIN_READY;
  logic        DEV_ACK, DEV_INT, sent;
  logic [15:0] STATUS, csr, maxp, fsz;
  logic [31:0] DEV_RDATA;
  logic [43:0] sent_pkt;
  logic [43:0] exp_q[$];
  dev_req_s    DEV_REQ;
  int          bad_count = 0;
  int          checks = 0;
  int          stalls = 0;

  always #2 MCLK = ~MCLK;

  usb_bulk_in_host #(.BUF_DEPTH(2)) uut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD(CMD), .DONE(DONE),
    .STALL_SEEN(STALL_SEEN), .STATUS(STATUS), .DIN_VALID(DIN_VALID),
    .DIN_READY(DIN_READY), .DIN_DATA(DIN_DATA), .DEV_REQ(DEV_REQ),
    .DEV_ACK(DEV_ACK), .DEV_RDATA(DEV_RDATA), .DEV_INT(DEV_INT));

  usb_dev_model dev (
    .clk(MCLK), .rst(SYS_RST), .req(DEV_REQ), .ack(DEV_ACK),
    .rdata(DEV_RDATA), .intr(DEV_INT), .ack_wait(ack_wait),
    .in_tok(in_tok), .sent(sent), .sent_pkt(sent_pkt), .csr(csr),
    .maxp(maxp), .fsz(fsz));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [43:0] seen, input logic [43:0] expd);
    checks++;
    if (seen !== expd)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, expd);
    end
  endtask

  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A wait that ran out of cycles ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      bad_count++;
      $display("unexpected at %0t: wait ran out", $time);
      summarize();
    end
  endtask

  task automatic run(input logic [2:0] op, input logic [15:0] arg);
    int n;
    logic [31:0] r;
    r = rnd();
    @(posedge MCLK);
    ack_wait <= r[1:0];
    CMD <= cmd_s'({op, arg});
    CMD_VALID <= 1'b1;
    n = 0;
    do
    begin
      @(negedge MCLK);
      n++;
    end
    while (CMD_READY !== 1'b1 && n < 4000);
    @(posedge MCLK);
    CMD_VALID <= 1'b0;
    if (op == 3'h0 || op == 3'h4)
      tog_x = 1'b0; // Both commands restart the data toggle
    do
    begin
      @(negedge MCLK);
      n++;
    end
    while (DONE !== 1'b1 && n < 8000);
    bound(n, 8000);
  endtask

  // Feeds random words; keep notes the packet that should reach the host
  task automatic feed(input int cnt, input bit keep);
    int k;
    int n;
    logic [31:0] s;
    logic [31:0] v;
    s = 0;
    n = 0;
    @(posedge MCLK);
    for (k = 0; k < cnt; k++)
    begin
      v = rnd();
      s = s + v;
      DIN_DATA <= v;
      DIN_VALID <= 1'b1;
      do
      begin
        @(negedge MCLK);
        n++;
      end
      while (DIN_READY !== 1'b1 && n < 4000);
      bound(n, 4000);
      @(posedge MCLK);
    end
    DIN_VALID <= 1'b0;
    if (keep)
    begin
      exp_q.push_back({tog_x, cnt[10:0], s});
      tog_x = ~tog_x;
    end
  endtask

  task automatic send(input int cnt, input bit keep);
    fork
      feed(cnt, keep);
      run(3'h1, cnt[15:0]);
    join
  endtask

  // Host token source; idle between bursts when disabled
  // No retry after a stall was seen, else the cleared flag comes back
  always @(posedge MCLK)
    in_tok <= tok_en && !(csr[4] && stalls != 0) && (rnd() % 8 == 0);

  // Compares every packet the host receives against the oldest note
  always @(negedge MCLK)
  begin
    if (STALL_SEEN === 1'b1)
      stalls++;
    if (sent === 1'b1)
      check(sent_pkt, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge MCLK);
    SYS_RST <= 1'b0;
    // Single buffer: plain, zero-length and full-payload packets
    run(3'h0, 16'h0040);
    check(maxp, 16'h0040);
    check(fsz[4], 1'b0);
    check(csr[14:10], 5'h08);
    tok_en <= 1'b1;
    send(3, 1'b1);
    check(STATUS[1:0], 2'b00);
    send(0, 1'b1);
    send(16, 1'b1);
    repeat (100) @(posedge MCLK);
    check(exp_q.size(), 0);
    // Double buffer: first packet frees the slot at once, order kept
    tok_en <= 1'b0;
    run(3'h0, 16'h8040);
    check(fsz[4], 1'b1);
    send(2, 1'b1);
    check(STATUS[1:0], 2'b10);
    tok_en <= 1'b1;
    send(1, 1'b1);
    repeat (100) @(posedge MCLK);
    check(exp_q.size(), 0);
    // A flushed packet must never reach the host
    tok_en <= 1'b0;
    send(1, 1'b0);
    run(3'h2, 16'h0000);
    tok_en <= 1'b1;
    send(2, 1'b1);
    repeat (100) @(posedge MCLK);
    check(exp_q.size(), 0);
    // Stall request answered, flag cleared, request kept
    run(3'h0, 16'h0040);
    run(3'h3, 16'h0000);
    check(csr[4], 1'b1);
    send(1, 1'b1);
    check(stalls, 1);
    check(csr[5:4], 2'b01);
    run(3'h4, 16'h0000);
    repeat (100) @(posedge MCLK);
    check(csr[4], 1'b0);
    check(exp_q.size(), 0);
    // Unknown command still completes
    run(3'h7, 16'h0000);
    summarize();
  end
endmodule // usb_bulk_in_host_test
